//--- hw/mppt_cfg_pkg.sv
// package: register layouts, reset values, codes and engine states of the converter config bank
package mppt_cfg_pkg;

   // ********************************
   // register word layouts
   // ********************************
   typedef struct packed {
      logic [8:0] rsvd_top;
      logic override_en;
      logic rsvd_45;
      logic [1:0] rsvd_44;
      logic power_thr_sel;
      logic [1:0] bypass_entry_select;
      logic [9:0] iout_max;
      logic [9:0] vout_max;
      logic [2:0] dead_off;
      logic [2:0] dead_on;
      logic [8:0] open_loop_duty;
      logic bypass_sel;
      logic bypass_manual_value;
      logic converter_soft_reset;
      logic clk_out_en;
      logic open_loop;
   } ctrl_type;

   typedef struct packed {
      logic [23:0] rsvd;
      logic [7:0] vout_ofs;
      logic [7:0] iout_ofs;
      logic [7:0] vin_ofs;
      logic [7:0] iin_ofs;
   } offs_type;

   typedef struct packed {
      logic [15:0] rsvd;
      logic [9:0] input_current_high_threshold;
      logic [9:0] input_current_low_threshold;
      logic [9:0] output_current_high_threshold;
      logic [9:0] output_current_low_threshold;
   } thr_type;

   // strap channel readings: ch6, ch4 (current limit), mode_strap_channel, ch0 (voltage limit)
   typedef struct packed {
      logic [9:0] ch6;
      logic [9:0] ch4;
      logic [9:0] mode_strap_channel;
      logic [9:0] ch0;
   } strap_adc_type;

   typedef struct packed {
      logic [9:0] vout;
      logic [9:0] iout;
      logic [9:0] vin;
      logic [9:0] iin;
   } meas_type;

   typedef struct packed {
      logic [9:0] current_limit;
      logic [9:0] voltage_limit;
      logic exit_thr_sel;
      logic [1:0] entry_sel;
      logic open_loop;
      logic [8:0] open_loop_duty;
      logic bypass_active;
      logic track_enter;
      logic track_exit;
   } cfg_out_type;

   // ********************************
   // reset values
   // ********************************
   localparam ctrl_type CTRL_RESET = '{rsvd_44: 2'h1, iout_max: 10'h3FF, vout_max: 10'h3FF,
      dead_off: 3'h3, dead_on: 3'h3, open_loop_duty: 9'hFF, default: '0};
   localparam offs_type OFFS_RESET = '0;
   localparam thr_type THR_RESET = '{rsvd: 16'h0, input_current_high_threshold: 10'h28,
      input_current_low_threshold: 10'h18, output_current_high_threshold: 10'h28,
      output_current_low_threshold: 10'h18};

   // ********************************
   // bus codes
   // ********************************
   localparam logic [3:0] ADDR_HIGH = 4'h0;
   localparam logic [7:0] CMD_BASE = 8'hE0;
   localparam logic [2:0] REG_STRAP = 3'h0;
   localparam logic [2:0] REG_MEAS = 3'h1;
   localparam logic [2:0] REG_CTRL = 3'h3;
   localparam logic [2:0] REG_OFFS = 3'h4;
   localparam logic [2:0] REG_THR = 3'h5;
   localparam logic [2:0] LAST_BYTE = 3'h6;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int MEAS_FLAG_BIT = 40;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_CMD = 4'h3,
      ST_CMD_ACK = 4'h4,
      ST_WDATA = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA = 4'h7,
      ST_RDATA_ACK = 4'h8
   } i2c_state_type;

endpackage

//--- hw/mppt_i2c_config_registers.sv
// serial-bus slave with the control, offset and threshold words of the converter controller
`timescale 1ns/10ps

// Contract
// - override bit selects register limits over straps
// - bit 42 replaces mode bit 9
// - bits 41:40 replace mode bits 8:7
// - field 39:30 is current limit, resets 1023
// - field 29:20 is voltage limit, resets 1023
// - open loop drives duty from 13:5
// - bypass select bit uses manual bit 3
// - bit 1 gates clock onto output pin
// - offset word: four bytes, reset zero
// - threshold word: four fields, 40 and 24
// - thresholds compared against current samples
// - address low bits from three straps
// - command codes start at 0xE0
// - words 0,1 read-only; 3,4,5 read-write
// - writes commit only after seven whole bytes
// - read bytes go least significant first
// - low bypass pin enters bypass mode
// - word 1 bit 40 shows tracking start
module mppt_i2c_config_registers (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic address_strap_0_i,
   input wire logic address_strap_1_i,
   input wire logic address_strap_2_i,
   input wire logic bypass_request_pin_n_i,
   input wire logic pll_clk_i,
   output logic clk_out_o,
   input wire mppt_cfg_pkg::strap_adc_type strap_adc_i,
   input wire mppt_cfg_pkg::meas_type meas_i,
   input wire logic tracking_start_i,
   output mppt_cfg_pkg::cfg_out_type cfg_o,
   output mppt_cfg_pkg::offs_type offsets_o,
   output logic converter_soft_reset_o,
   output logic bypass_drive_output_o
);
   import mppt_cfg_pkg::*;

   // ********************************
   // pin synchronisers and bus events
   // ********************************
   logic scl_s;
   logic sda_s;
   logic [2:0] strap_s;
   logic bypass_req_n_s;
   logic scl_d_ff;
   logic sda_d_ff;

   // bus lines and bypass pin idle high, so they reset high: no false start or bypass request
   pin_sync #(.W(6), .RST_VAL(6'h31)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i({scl_i, sda_i, address_strap_2_i, address_strap_1_i, address_strap_0_i,
         bypass_request_pin_n_i}),
      .sync_o({scl_s, sda_s, strap_s, bypass_req_n_s})
   );

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   wire scl_rise_w = scl_s & ~scl_d_ff;
   wire scl_fall_w = ~scl_s & scl_d_ff;
   wire start_w = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   wire stop_w = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // ********************************
   // slave engine state
   // ********************************
   i2c_state_type state_ff;
   logic [3:0] bit_cnt_ff;
   logic [2:0] byte_cnt_ff;
   logic [7:0] shift_ff;
   logic [2:0] sel_ff;
   logic rw_ff;
   logic mnack_ff;
   logic sda_oe_ff;
   logic [55:0] wbuf_ff;
   logic [55:0] rbuf_ff;
   ctrl_type ctrl_ff;
   offs_type offs_ff;
   thr_type thr_ff;

   wire [6:0] dev_addr_w = {ADDR_HIGH, strap_s};
   wire addr_match_w = shift_ff[7:1] == dev_addr_w;
   wire [2:0] cmd_idx_w = shift_ff[2:0];
   wire cmd_known_w = (cmd_idx_w == REG_STRAP) | (cmd_idx_w == REG_MEAS) | (cmd_idx_w == REG_CTRL) |
      (cmd_idx_w == REG_OFFS) | (cmd_idx_w == REG_THR);
   wire cmd_valid_w = (shift_ff[7:3] == CMD_BASE[7:3]) & cmd_known_w;
   wire writable_w = (sel_ff == REG_CTRL) | (sel_ff == REG_OFFS) | (sel_ff == REG_THR);
   wire byte_done_w = bit_cnt_ff == BITS_PER_BYTE;
   wire last_byte_w = byte_cnt_ff == LAST_BYTE;
   wire tx_bit_w = rbuf_ff[{byte_cnt_ff, ~bit_cnt_ff[2:0]}];
   wire [2:0] byte_nxt_w = byte_cnt_ff + 3'h1;
   wire next_first_w = rbuf_ff[{byte_nxt_w, 3'h7}];
   wire rd_lsb_w = rbuf_ff[7];
   wire commit_w = scl_fall_w & (state_ff == ST_WDATA) & byte_done_w & last_byte_w & writable_w;
   wire [55:0] wr_word_w = {shift_ff, wbuf_ff[47:0]};

   logic [55:0] rd_word_w;
   always_comb begin
      rd_word_w = '0;
      case (sel_ff)
         REG_STRAP: rd_word_w = {16'h0, strap_adc_i};
         REG_MEAS: rd_word_w = {15'h0, tracking_start_i, meas_i};
         REG_CTRL: rd_word_w = ctrl_ff;
         REG_OFFS: rd_word_w = offs_ff;
         REG_THR: rd_word_w = thr_ff;
         default: rd_word_w = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         byte_cnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         sel_ff <= REG_STRAP;
         rw_ff <= 1'b0;
         mnack_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         wbuf_ff <= '0;
         rbuf_ff <= '0;
      end else if (start_w) begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         sda_oe_ff <= 1'b0;
      end else if (stop_w) begin
         state_ff <= ST_IDLE; // a write cut short here never reaches commit
         sda_oe_ff <= 1'b0;
      end else if (scl_rise_w) begin
         if (state_ff == ST_RDATA_ACK) begin
            mnack_ff <= sda_s;
         end
         if ((state_ff == ST_ADDR) || (state_ff == ST_CMD) || (state_ff == ST_WDATA)) begin
            shift_ff <= {shift_ff[6:0], sda_s};
         end
         if ((state_ff == ST_ADDR) || (state_ff == ST_CMD) || (state_ff == ST_WDATA) ||
               (state_ff == ST_RDATA)) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (scl_fall_w) begin
         case (state_ff)
            ST_ADDR: begin
               if (byte_done_w) begin
                  state_ff <= addr_match_w ? ST_ADDR_ACK : ST_IDLE;
                  sda_oe_ff <= addr_match_w;
                  rw_ff <= shift_ff[0];
                  rbuf_ff <= rd_word_w; // snapshot so a read sees one coherent word
               end
            end
            ST_ADDR_ACK: begin
               bit_cnt_ff <= 4'h0;
               byte_cnt_ff <= 3'h0;
               state_ff <= rw_ff ? ST_RDATA : ST_CMD;
               sda_oe_ff <= rw_ff & ~rd_lsb_w;
            end
            ST_CMD: begin
               if (byte_done_w) begin
                  state_ff <= cmd_valid_w ? ST_CMD_ACK : ST_IDLE;
                  sda_oe_ff <= cmd_valid_w;
                  sel_ff <= cmd_valid_w ? cmd_idx_w : sel_ff;
               end
            end
            ST_CMD_ACK: begin
               sda_oe_ff <= 1'b0;
               bit_cnt_ff <= 4'h0;
               byte_cnt_ff <= 3'h0;
               state_ff <= ST_WDATA;
            end
            ST_WDATA: begin
               if (byte_done_w) begin
                  state_ff <= writable_w ? ST_WDATA_ACK : ST_IDLE;
                  sda_oe_ff <= writable_w;
                  wbuf_ff[{byte_cnt_ff, 3'h0} +: 8] <= shift_ff;
               end
            end
            ST_WDATA_ACK: begin
               sda_oe_ff <= 1'b0;
               bit_cnt_ff <= 4'h0;
               byte_cnt_ff <= byte_nxt_w;
               state_ff <= last_byte_w ? ST_IDLE : ST_WDATA; // an eighth byte gets no ack
            end
            ST_RDATA: begin
               if (byte_done_w) begin
                  sda_oe_ff <= 1'b0;
                  state_ff <= ST_RDATA_ACK;
               end else begin
                  sda_oe_ff <= ~tx_bit_w;
               end
            end
            ST_RDATA_ACK: begin
               bit_cnt_ff <= 4'h0;
               if (mnack_ff || last_byte_w) begin
                  state_ff <= ST_IDLE;
                  sda_oe_ff <= 1'b0;
               end else begin
                  byte_cnt_ff <= byte_nxt_w;
                  state_ff <= ST_RDATA;
                  sda_oe_ff <= ~next_first_w;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               sda_oe_ff <= 1'b0;
            end
         endcase
      end
   end

   // ********************************
   // register words
   // ********************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= CTRL_RESET;
         offs_ff <= OFFS_RESET;
         thr_ff <= THR_RESET;
      end else if (commit_w) begin
         case (sel_ff)
            REG_CTRL: ctrl_ff <= wr_word_w;
            REG_OFFS: offs_ff <= wr_word_w;
            REG_THR: thr_ff <= wr_word_w;
            default: ctrl_ff <= ctrl_ff;
         endcase
      end
   end

   // ********************************
   // derived controls
   // ********************************
   wire ovr_w = ctrl_ff.override_en;
   wire [9:0] mode_w = strap_adc_i.mode_strap_channel;
   cfg_out_type nxt_cfg;

   always_comb begin
      nxt_cfg.current_limit = ovr_w ? ctrl_ff.iout_max : strap_adc_i.ch4;
      nxt_cfg.voltage_limit = ovr_w ? ctrl_ff.vout_max : strap_adc_i.ch0;
      nxt_cfg.exit_thr_sel = ovr_w ? ctrl_ff.power_thr_sel : mode_w[9];
      nxt_cfg.entry_sel = ovr_w ? ctrl_ff.bypass_entry_select : mode_w[8:7];
      nxt_cfg.open_loop = ctrl_ff.open_loop;
      nxt_cfg.open_loop_duty = ctrl_ff.open_loop_duty;
      nxt_cfg.bypass_active = ctrl_ff.bypass_sel ? ctrl_ff.bypass_manual_value : ~bypass_req_n_s;
      nxt_cfg.track_enter = (meas_i.iin >= thr_ff.input_current_high_threshold) &
         (meas_i.iout >= thr_ff.output_current_high_threshold);
      nxt_cfg.track_exit = (meas_i.iin < thr_ff.input_current_low_threshold) |
         (meas_i.iout < thr_ff.output_current_low_threshold);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_o <= '0;
      end else begin
         cfg_o <= nxt_cfg;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_ff;
   assign offsets_o = offs_ff;
   // host enters open loop by setting bit 0 then pulsing this bit
   assign converter_soft_reset_o = ctrl_ff.converter_soft_reset;
   assign bypass_drive_output_o = cfg_o.bypass_active;
   // gated clock passes straight through; glitches at enable changes are tolerated by the pin user
   assign clk_out_o = ctrl_ff.clk_out_en & pll_clk_i;

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence cmd_byte_s;
      scl_fall_w && (state_ff == ST_CMD) && byte_done_w && cmd_valid_w && !start_w && !stop_w;
   endsequence
   sequence cmd_acked_s;
      sda_oe_ff && (state_ff == ST_CMD_ACK);
   endsequence

   ovr_current_a: assert property (ovr_w |=> cfg_o.current_limit == $past(ctrl_ff.iout_max))
      else $error("override current limit not taken");
   strap_current_a: assert property (!ovr_w |=> cfg_o.current_limit == $past(strap_adc_i.ch4))
      else $error("strap current limit not taken");
   ovr_voltage_a: assert property (ovr_w |=> cfg_o.voltage_limit == $past(ctrl_ff.vout_max))
      else $error("override voltage limit not taken");
   exit_sel_a: assert property (ovr_w |=> cfg_o.exit_thr_sel == $past(ctrl_ff.power_thr_sel))
      else $error("exit threshold select wrong");
   entry_sel_a: assert property (!ovr_w |=> cfg_o.entry_sel == $past(mode_w[8:7]))
      else $error("entry select not from mode channel");
   open_duty_a: assert property (ctrl_ff.open_loop |=> cfg_o.open_loop &&
      cfg_o.open_loop_duty == $past(ctrl_ff.open_loop_duty)) else $error("open loop duty wrong");
   bypass_manual_a: assert property (ctrl_ff.bypass_sel ##1 ctrl_ff.bypass_sel |->
      bypass_drive_output_o == $past(ctrl_ff.bypass_manual_value)) else $error("manual bypass ignored");
   bypass_pin_a: assert property (!ctrl_ff.bypass_sel && !bypass_req_n_s |=> bypass_drive_output_o)
      else $error("bypass pin request ignored");
   clk_gate_a: assert property (!ctrl_ff.clk_out_en |-> !clk_out_o)
      else $error("clock output not gated");
   track_enter_a: assert property ((meas_i.iin < thr_ff.input_current_high_threshold) |=>
      !cfg_o.track_enter) else $error("tracking entry below threshold");
   addr_ack_a: assert property (scl_fall_w && (state_ff == ST_ADDR) && byte_done_w && !addr_match_w &&
      !start_w && !stop_w |=> (state_ff == ST_IDLE) && !sda_oe_ff) else $error("foreign address acked");
   cmd_ack_a: assert property (cmd_byte_s |=> cmd_acked_s)
      else $error("valid command not acked");
   ro_write_a: assert property (scl_fall_w && (state_ff == ST_WDATA) && byte_done_w && !writable_w &&
      !start_w && !stop_w |=> (state_ff == ST_IDLE) && !sda_oe_ff) else $error("read-only word acked data");
   whole_write_a: assert property ($changed(thr_ff) || $changed(offs_ff) || $changed(ctrl_ff) |->
      $past(commit_w)) else $error("register changed without full block");
   lsb_first_a: assert property (scl_fall_w && (state_ff == ST_ADDR_ACK) && rw_ff && !start_w &&
      !stop_w |=> sda_oe_ff == !$past(rd_lsb_w)) else $error("read did not start with lsb");
endmodule

//--- hw/pin_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_ff;

   generate
      if (W < 1) begin : g_bad_width
         $error("pin_sync width must be at least one");
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_ff <= async_i;
         sync_o <= meta_ff;
      end
   end
endmodule

//--- testbench/i2c_host_model.sv
// serial-bus host model that drives the clock and data pins of the config bank
`timescale 1ns/10ps
module i2c_host_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // ************************************
   // pin timing, four cycles a quarter bit
   // ************************************
   // bus idles with both lines released, the clock stands still between frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // data moves 4 cycles after the clock falls, bit period 80 ns
   task automatic bit_xfer(input logic b, output logic r);
      sda_o <= b;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      r = sda_i;
      tick(4);
      scl_o <= 1'b0;
      tick(4);
   endtask

   task automatic start();
      sda_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b0;
      tick(4);
   endtask

   task automatic stop();
      sda_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= 1'b1;
      tick(8);
   endtask

   // ************************************
   // byte and word transfers
   // ************************************
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask

   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, r);
         d[i] = r;
      end
      bit_xfer(last, r);
   endtask

   // command first, then n data bytes lsb first; n below 7 makes a short write
   task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [55:0] d, input int n,
      output logic [8:0] ak);
      start();
      send_byte({a, 1'b0}, ak[0]);
      send_byte(c, ak[1]);
      for (int k = 0; k < 7; k++) begin
         ak[k + 2] = 1'b0;
         if (k < n) send_byte(d[8 * k +: 8], ak[k + 2]);
      end
      stop();
   endtask

   // host acks six bytes and refuses the seventh
   task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [55:0] d,
      output logic [2:0] ak);
      logic [7:0] b;
      start();
      send_byte({a, 1'b0}, ak[0]);
      send_byte(c, ak[1]);
      start();
      send_byte({a, 1'b1}, ak[2]);
      for (int k = 0; k < 7; k++) begin
         get_byte(k == 6, b);
         d[8 * k +: 8] = b;
      end
      stop();
   endtask
endmodule

//--- testbench/mppt_i2c_config_registers_tb.sv
// self-checking bench of the converter config register bank
`timescale 1ns/10ps
`define CHECK_EQ(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module mppt_i2c_config_registers_tb;
   import mppt_cfg_pkg::*;
   // ************************************
   // constants and cases
   // ************************************
   typedef struct packed {
      logic [7:0] cmd;
      logic [55:0] wdata;
      logic [8:0] acks;
      logic [55:0] rdata;
   } row_type;
   localparam logic [6:0] ADR = 7'h05;
   localparam strap_adc_type STRAPS = '{ch6: 10'h2C1, ch4: 10'h155, mode_strap_channel: 10'h300, ch0: 10'h0AA};
   localparam meas_type MEAS0 = '{vout: 10'h3C3, iout: 10'h0F0, vin: 10'h20F, iin: 10'h111};
   localparam logic [55:0] THR_EXP = {16'h0, 10'h028, 10'h018, 10'h028, 10'h018};
   localparam row_type ROWS [5] = '{
      '{8'hE3, 56'h5A_A5C3_3CF0_0F96, 9'h1FF, 56'h5A_A5C3_3CF0_0F96},
      '{8'hE4, 56'h12_3456_789A_BCDE, 9'h1FF, 56'h12_3456_789A_BCDE},
      '{8'hE5, 56'hFE_DCBA_9876_5432, 9'h1FF, 56'hFE_DCBA_9876_5432},
      '{8'hE0, 56'h11_2233_4455_6677, 9'h003, {16'h0, STRAPS}},
      '{8'hE1, 56'h11_2233_4455_6677, 9'h003, {15'h0, 1'b1, MEAS0}}};
   // input current, output current, expected enter and exit
   localparam logic [21:0] TCASES [6] = '{{10'h028, 10'h028, 2'h2}, {10'h027, 10'h028, 2'h0},
      {10'h028, 10'h027, 2'h0}, {10'h017, 10'h020, 2'h1}, {10'h020, 10'h017, 2'h1}, {10'h018, 10'h018, 2'h0}};
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic scl, host_sda, sda_o, sda_oe, clk_out, srst, byp_out, trk, byp_n;
   logic pll_clk = 1'b0;
   logic [2:0] straps;
   strap_adc_type adc;
   meas_type meas;
   cfg_out_type cfg;
   offs_type offs;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // open-drain wire with pull-up
   wire logic sda = host_sda & ~(sda_oe & ~sda_o);

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) pll_clk <= ~pll_clk;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         errors++;
         final_report();
      end
   end

   mppt_i2c_config_registers dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .address_strap_0_i(straps[0]), .address_strap_1_i(straps[1]),
      .address_strap_2_i(straps[2]), .bypass_request_pin_n_i(byp_n), .pll_clk_i(pll_clk),
      .clk_out_o(clk_out), .strap_adc_i(adc), .meas_i(meas), .tracking_start_i(trk), .cfg_o(cfg),
      .offsets_o(offs), .converter_soft_reset_o(srst), .bypass_drive_output_o(byp_out));

   i2c_host_model host_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

   // ************************************
   // shared tasks
   // ************************************
   task automatic final_report();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic done(input string s);
      $display("test %s done at %0t", s, $time);
   endtask

   task automatic do_reset();
      rst_n_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic check_resets();
      logic [55:0] d;
      logic [2:0] ak;
      `CHECK_EQ(offs, 56'h0)
      host_u.read_word(ADR, 8'hE3, d, ak);
      `CHECK_EQ(d, 56'h0008FFFFF6DFE0)
      host_u.read_word(ADR, 8'hE4, d, ak);
      `CHECK_EQ(d, 56'h0)
      host_u.read_word(ADR, 8'hE5, d, ak);
      `CHECK_EQ(d, THR_EXP)
      `CHECK_EQ(ak, 3'h7)
      done("reset values");
   endtask

   // ************************************
   // main sequence
   // ************************************
   initial begin
      ctrl_type c;
      logic [55:0] d;
      logic [8:0] wak;
      logic [2:0] rak;
      trk = 1'b1;
      byp_n = 1'b1;
      straps = 3'h5;
      adc = STRAPS;
      meas = MEAS0;
      do_reset();
      check_resets();
      foreach (ROWS[i]) begin
         host_u.write_word(ADR, ROWS[i].cmd, ROWS[i].wdata, 7, wak);
         `CHECK_EQ(wak, ROWS[i].acks)
         host_u.read_word(ADR, ROWS[i].cmd, d, rak);
         `CHECK_EQ(d, ROWS[i].rdata)
         if (ROWS[i].cmd == 8'hE4) `CHECK_EQ(offs, ROWS[i].wdata)
      end
      done("word table");
      // update the control word from its read-back value
      host_u.read_word(ADR, 8'hE3, c, rak);
      c.override_en = 1'b0;
      c.open_loop = 1'b0;
      c.converter_soft_reset = 1'b0;
      host_u.write_word(ADR, 8'hE3, c, 7, wak);
      `CHECK_EQ({cfg.current_limit, cfg.voltage_limit}, {STRAPS.ch4, STRAPS.ch0})
      `CHECK_EQ({cfg.exit_thr_sel, cfg.entry_sel}, STRAPS.mode_strap_channel[9:7])
      c.override_en = 1'b1;
      for (int k = 0; k < 4; k++) begin
         c.bypass_entry_select = k[1:0];
         c.power_thr_sel = k[0];
         c.iout_max = {8'h5A, k[1:0]};
         c.vout_max = {k[1:0], 8'hC3};
         host_u.write_word(ADR, 8'hE3, c, 7, wak);
         `CHECK_EQ({cfg.exit_thr_sel, cfg.entry_sel}, {k[0], k[1:0]})
         `CHECK_EQ({cfg.current_limit, cfg.voltage_limit}, {8'h5A, k[1:0], k[1:0], 8'hC3})
      end
      done("override");
      // open loop: set mode, then pulse the soft reset
      c.open_loop = 1'b1;
      c.open_loop_duty = 9'h1A5;
      host_u.write_word(ADR, 8'hE3, c, 7, wak);
      c.converter_soft_reset = 1'b1;
      host_u.write_word(ADR, 8'hE3, c, 7, wak);
      `CHECK_EQ(srst, 1'b1)
      c.converter_soft_reset = 1'b0;
      host_u.write_word(ADR, 8'hE3, c, 7, wak);
      `CHECK_EQ({srst, cfg.open_loop, cfg.open_loop_duty}, {1'b0, 1'b1, 9'h1A5})
      done("open loop");
      for (int j = 0; j < 8; j++) begin
         c.bypass_sel = j[2];
         c.bypass_manual_value = j[1];
         if (!j[0]) host_u.write_word(ADR, 8'hE3, c, 7, wak);
         byp_n <= j[0];
         repeat (8) @(posedge clk_i);
         `CHECK_EQ({byp_out, cfg.bypass_active}, {2{j[2] ? j[1] : ~j[0]}})
      end
      done("bypass");
      for (int j = 0; j < 2; j++) begin
         c.clk_out_en = j[0];
         host_u.write_word(ADR, 8'hE3, c, 7, wak);
         repeat (8) begin
            @(negedge clk_i);
            `CHECK_EQ(clk_out, pll_clk & j[0])
         end
      end
      done("clock output");
      host_u.write_word(ADR, 8'hE5, THR_EXP, 7, wak);
      foreach (TCASES[j]) begin
         @(posedge clk_i);
         meas.iin <= TCASES[j][21:12];
         meas.iout <= TCASES[j][11:2];
         repeat (4) @(posedge clk_i);
         `CHECK_EQ({cfg.track_enter, cfg.track_exit}, TCASES[j][1:0])
      end
      done("thresholds");
      host_u.write_word(ADR, 8'hE5, 56'h0, 3, wak);
      `CHECK_EQ(wak, 9'h01F)
      host_u.read_word(ADR, 8'hE5, d, rak);
      `CHECK_EQ(d, THR_EXP)
      host_u.write_word(7'h06, 8'hE4, 56'h0, 7, wak);
      `CHECK_EQ(wak, 9'h000)
      host_u.write_word(ADR, 8'hE2, 56'h0, 7, wak);
      `CHECK_EQ(wak, 9'h001)
      done("refusals");
      // straps and tracking flag moved while running
      straps <= 3'h6;
      trk <= 1'b0;
      host_u.write_word(7'h06, 8'hE4, 56'h0, 7, wak);
      `CHECK_EQ(wak, 9'h1FF)
      host_u.read_word(7'h06, 8'hE1, d, rak);
      `CHECK_EQ(d, {16'h0, meas})
      straps <= 3'h5;
      done("straps and flag");
      do_reset();
      check_resets();
      final_report();
   end
endmodule
